// file: bench/tb_tws_slave.sv
// Self-checking bench for the two-wire slave interface
`define CHK(name, exp, got) begin \
    n_tests++; \
    if ((got) !== (exp)) begin \
        $display("CHECK FAILED %s expected %h seen %h", name, exp, got); \
        error_cnt++; \
    end \
end
module tb_tws_slave
    import tws_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] NEW_W = {TWS_ADDR_FIXED, 4'h9, 1'b0};
    localparam logic [7:0] NEW_R = {TWS_ADDR_FIXED, 4'h9, 1'b1};
    logic sys_clk = 1'b0;
    logic link_clk = 1'b0;
    logic rst_n = 1'b0;
    logic scl;
    logic m_low;
    logic sda_w;
    logic sda_out;
    logic sda_oe;
    logic [3:0] addr_select;
    int error_cnt = 0;
    int n_tests = 0;
    // Wired-AND data line with pull-up
    assign sda_w = (sda_oe ? sda_out : 1'b1) & ~m_low;
    // System clock and offset link clock
    always #5 sys_clk = ~sys_clk;
    initial begin
        #1.7;
        forever #3 link_clk = ~link_clk;
    end
    tws_slave tws_slave_inst (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .link_clk(link_clk),
        .scl_in(scl),
        .sda_in(sda_w),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .addr_select(addr_select)
    );
    tws_master tws_master_inst (
        .clk(sys_clk),
        .scl(scl),
        .sda_low(m_low),
        .sda(sda_w)
    );
    // Prints counts and verdict, then stops
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Sends one byte and checks the device reply
    task automatic tx(input logic [7:0] b, input logic exp_ack);
        logic ack, bad;
        tws_master_inst.wr_byte(b, ack, bad);
        `CHK("acknowledge", exp_ack, ack)
        `CHK("line free while receiving", 1'b0, bad)
    endtask
    // Reads one byte and checks value and stability
    task automatic rx(input logic nak, input logic [7:0] exp, input logic chk);
        logic [7:0] b;
        logic bad;
        tws_master_inst.rd_byte(nak, b, bad);
        if (chk) `CHK("read byte", exp, b)
        `CHK("data stable while clock high", 1'b0, bad)
    endtask
    // Device may only pull the line low
    always @(negedge sys_clk) begin
        if (rst_n && sda_oe === 1'b1) `CHK("open drain level", 1'b0, sda_out)
    end
    // Hang guard, about 100k system clocks
    initial begin
        #1_000_000;
        error_cnt++;
        end_of_test();
    end
    // Main sequence of bus transactions
    initial begin
        repeat (10) @(posedge sys_clk);
        @(negedge sys_clk);
        rst_n = 1'b1;
        `CHK("select after reset", TWS_SEL_RESET, addr_select)
        repeat (10) @(negedge sys_clk);
        tws_master_inst.start();
        tx(8'h6c, 1'b1);
        tws_master_inst.stop();
        tws_master_inst.start();
        tx(8'h70, 1'b0);
        tx(8'h00, 1'b0);
        tws_master_inst.stop();
        tws_master_inst.start();
        tx(8'h6c, 1'b1);
        tx(8'h4e, 1'b1);
        tx(8'ha5, 1'b1);
        tx(8'h3c, 1'b1);
        tx(8'h77, 1'b1);
        tws_master_inst.stop();
        tws_master_inst.start();
        tx(8'h6c, 1'b1);
        tx(8'h4e, 1'b1);
        tws_master_inst.start();
        tx(8'h6d, 1'b1);
        rx(1'b0, 8'ha5, 1'b1);
        rx(1'b0, 8'h3c, 1'b1);
        rx(1'b1, TWS_READ_PAST, 1'b1);
        `CHK("released after master nak", 1'b0, sda_oe)
        tws_master_inst.stop();
        tws_master_inst.start();
        tx(8'h6c, 1'b1);
        tx(TWS_CFG_OFFSET, 1'b1);
        tx(8'h9f, 1'b1);
        tws_master_inst.stop();
        `CHK("select field", 4'h9, addr_select)
        tws_master_inst.start();
        tx(8'h6c, 1'b0);
        tws_master_inst.stop();
        tws_master_inst.start();
        tx(NEW_W, 1'b1);
        tx(TWS_CFG_OFFSET, 1'b1);
        tws_master_inst.start();
        tx(NEW_R, 1'b1);
        rx(1'b1, 8'h90, 1'b1);
        tws_master_inst.stop();
        tws_master_inst.start();
        tx(NEW_W, 1'b1);
        tx(8'hff, 1'b1);
        tws_master_inst.start();
        tx(NEW_R, 1'b1);
        rx(1'b0, TWS_READ_PAST, 1'b1);
        rx(1'b1, TWS_READ_PAST, 1'b1);
        tws_master_inst.stop();
        end_of_test();
    end
endmodule // tb_tws_slave

// file: bench/tws_master.sv
// Behavioural two-wire bus master that drives the link pins
module tws_master (
    input wire logic clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 1ps;
    // Quarter bit period, just under 400kHz at 100 MHz
    localparam int QTR = 63;
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // One quarter bit of wait, steps on falling edges
    task automatic q();
        repeat (QTR) @(negedge clk);
    endtask
    task automatic start();
        sda_low = 1'b0;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask
    task automatic stop();
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask
    task automatic bit_cyc(input logic drive_low, output logic s1, output logic s2);
        sda_low = drive_low;
        q();
        scl = 1'b1;
        q();
        s1 = sda;
        q();
        s2 = sda;
        scl = 1'b0;
        q();
    endtask
    task automatic wr_byte(input logic [7:0] b, output logic ack, output logic bad);
        logic s1, s2;
        bad = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(~b[i], s1, s2);
            bad |= (s1 !== b[i]);
        end
        bit_cyc(1'b0, s1, s2);
        ack = ~s1;
        bad |= (s1 !== s2);
    endtask
    task automatic rd_byte(input logic nak, output logic [7:0] b, output logic bad);
        logic s1, s2;
        bad = 1'b0;
        for (int i = 7; i >= 0; i--) begin
            bit_cyc(1'b0, s1, s2);
            b[i] = s1;
            bad |= (s1 !== s2);
        end
        bit_cyc(~nak, s1, s2);
        sda_low = 1'b0;
    endtask
endmodule // tws_master

// file: core/tws_pkg.sv
// Constants and types shared by the two-wire slave interface
package tws_pkg;
    // Slave address layout
    localparam logic [2:0] TWS_ADDR_FIXED = 3'h3;
    localparam logic [3:0] TWS_SEL_RESET = 4'h6;
    localparam int TWS_SEL_LSB = 4;
    // Memory map points
    localparam logic [7:0] TWS_CFG_OFFSET = 8'h7d;
    localparam logic [7:0] TWS_WR_LIMIT = 8'h4f;
    localparam logic [7:0] TWS_SHADOW_LO = 8'h60;
    localparam logic [7:0] TWS_SHADOW_HI = 8'h7f;
    localparam logic [7:0] TWS_READ_PAST = 8'hff;
    localparam logic [3:0] TWS_CFG_RSVD = 4'h0;
    // Serial framing
    localparam logic [3:0] TWS_BYTE_BITS = 4'h8;
    localparam int TWS_SCL_MAX_KHZ = 400;
    // Link-side sequencer states
    typedef enum logic [6:0] {
        ST_IDLE = 7'h01,
        ST_ADDR = 7'h02,
        ST_ACKT = 7'h04,
        ST_WRX = 7'h08,
        ST_TX = 7'h10,
        ST_ACKR = 7'h20,
        ST_IGN = 7'h40
    } tws_state_t;
endpackage : tws_pkg

// file: core/tws_slave.sv
// Two-wire slave interface with its memory map and cross-domain access
//
// What this block does
// - Works at any clock rate to 400kHz
// - Data pin input, only pulled low when driving
// - Slave only, never drives the clock
// - One bit per clock, data stable clock high
// - Data fall/rise while clock high: START/STOP
// - Repeated START begins a fresh transaction
// - Idle with both lines high; STOP returns idle
// - Acknowledge: hold data low through ninth pulse
// - Not-acknowledge: data released through ninth pulse
// - Eight bits MSB first, then acknowledge
// - Multibyte values MSB first at even address
// - Acknowledge own address after read/write bit
// - Address 011 plus four configurable bits
// - Read/write bit picks transfer direction
// - Default address bytes 6Ch write, 6Dh read
// - Address acknowledge shows device presence
// - Every byte acknowledged before the next
// - Address select field in bits 7-4
// - First write byte sets pointer, then auto-increment
// - Ignore writes outside writable range
// - Read: set pointer, repeated START, read bytes
// - Past top of map, return FFh
module tws_slave
    import tws_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic link_clk,
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic [3:0] addr_select
);
    // Link domain state
    logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
    tws_state_t state, next_state;
    logic [3:0] bitcnt, next_bitcnt;
    logic [7:0] sh, next_sh;
    logic [8:0] ptr, next_ptr;
    logic got_ptr, next_got_ptr, rw, next_rw, nak, next_nak;
    logic from_addr, next_from_addr, next_oe, issue;
    logic req_tgl, req_we, next_req_we;
    logic [7:0] req_addr, next_req_addr, req_wdata, next_req_wdata;
    logic ak_m, ak_s, ak_d;
    logic [7:0] rsp_l;
    logic [3:0] sel_l;
    // System domain state
    logic rq_m, rq_s, rq_d, ack_tgl;
    logic [7:0] rsp_data;
    logic [3:0] rsp_cfg;
    logic [7:0] mem [0:255];

    // Bus condition decode on synchronised lines
    wire start_c = scl_s & scl_d & sda_d & ~sda_s;
    wire stop_c = scl_s & scl_d & ~sda_d & sda_s;
    wire rise_c = scl_s & ~scl_d;
    wire fall_c = ~scl_s & scl_d;
    wire byte_done = (bitcnt == TWS_BYTE_BITS);
    wire addr_hit = (sh[7:1] == {TWS_ADDR_FIXED, sel_l});
    wire ak_ev = ak_s ^ ak_d;
    wire [8:0] ptr_inc = ptr[8] ? ptr : 9'(ptr + 9'h001);
    wire [7:0] rd_byte = ptr[8] ? TWS_READ_PAST : rsp_l;

    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            {scl_m, scl_s, scl_d} <= 3'h7;
            {sda_m, sda_s, sda_d} <= 3'h7;
        end else begin
            {scl_m, scl_s, scl_d} <= {scl_in, scl_m, scl_s};
            {sda_m, sda_s, sda_d} <= {sda_in, sda_m, sda_s};
        end
    end

    // Sequencer next-state logic
    always_comb begin
        next_state = state;
        next_bitcnt = bitcnt;
        next_sh = sh;
        next_ptr = ptr;
        next_got_ptr = got_ptr;
        next_rw = rw;
        next_nak = nak;
        next_from_addr = from_addr;
        next_oe = sda_oe;
        issue = 1'b0;
        next_req_we = req_we;
        next_req_addr = req_addr;
        next_req_wdata = req_wdata;
        if (start_c) begin
            next_state = ST_ADDR;
            next_bitcnt = 4'h0;
            next_oe = 1'b0;
        end else if (stop_c) begin
            next_state = ST_IDLE;
            next_oe = 1'b0;
        end else begin
            unique case (state)
                ST_IDLE, ST_IGN: begin
                    next_oe = 1'b0;
                end
                ST_ADDR, ST_WRX: begin
                    if (rise_c) begin
                        next_sh = {sh[6:0], sda_s};
                        next_bitcnt = 4'(bitcnt + 4'h1);
                    end else if (fall_c && byte_done) begin
                        if (state == ST_WRX || addr_hit) begin
                            next_state = ST_ACKT;
                            next_oe = 1'b1;
                            next_from_addr = (state == ST_ADDR);
                            if (state == ST_ADDR) begin
                                next_rw = sh[0];
                                next_got_ptr = sh[0] & got_ptr;
                                issue = sh[0];
                                next_req_we = 1'b0;
                                next_req_addr = ptr[7:0];
                            end
                        end else begin
                            next_state = ST_IGN;
                        end
                    end
                end
                ST_ACKT: begin
                    if (fall_c) begin
                        next_bitcnt = 4'h0;
                        if (rw) begin
                            next_state = ST_TX;
                            next_sh = rd_byte;
                            next_oe = ~rd_byte[7];
                        end else begin
                            next_state = ST_WRX;
                            next_oe = 1'b0;
                            if (!from_addr && !got_ptr) begin
                                next_ptr = {1'b0, sh};
                                next_got_ptr = 1'b1;
                            end else if (!from_addr) begin
                                issue = ~ptr[8];
                                next_req_we = 1'b1;
                                next_req_addr = ptr[7:0];
                                next_req_wdata = sh;
                                next_ptr = ptr_inc;
                            end
                        end
                    end
                end
                ST_TX: begin
                    if (rise_c) begin
                        next_bitcnt = 4'(bitcnt + 4'h1);
                    end else if (fall_c && byte_done) begin
                        next_state = ST_ACKR;
                        next_oe = 1'b0;
                        next_ptr = ptr_inc;
                        issue = 1'b1;
                        next_req_we = 1'b0;
                        next_req_addr = ptr_inc[7:0];
                    end else if (fall_c) begin
                        next_sh = {sh[6:0], 1'b1};
                        next_oe = ~sh[6];
                    end
                end
                ST_ACKR: begin
                    if (rise_c) begin
                        next_nak = sda_s;
                    end else if (fall_c && nak) begin
                        next_state = ST_IGN;
                    end else if (fall_c) begin
                        next_state = ST_TX;
                        next_bitcnt = 4'h0;
                        next_sh = rd_byte;
                        next_oe = ~rd_byte[7];
                    end
                end
            endcase
        end
    end

    // Sequencer registers
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            bitcnt <= 4'h0;
            sh <= 8'h00;
            ptr <= 9'h000;
            {got_ptr, rw, nak, from_addr} <= 4'h0;
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end else begin
            state <= next_state;
            bitcnt <= next_bitcnt;
            sh <= next_sh;
            ptr <= next_ptr;
            {got_ptr, rw, nak, from_addr} <= {next_got_ptr, next_rw, next_nak, next_from_addr};
            sda_oe <= next_oe;
            sda_out <= 1'b0;
        end
    end

    // Request launch toward the memory side
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            req_tgl <= 1'b0;
            req_we <= 1'b0;
            req_addr <= 8'h00;
            req_wdata <= 8'h00;
        end else begin
            req_tgl <= req_tgl ^ issue;
            req_we <= next_req_we;
            req_addr <= next_req_addr;
            req_wdata <= next_req_wdata;
        end
    end

    // Response capture from the memory side
    always_ff @(posedge link_clk or negedge rst_n) begin
        if (!rst_n) begin
            {ak_m, ak_s, ak_d} <= 3'h0;
            rsp_l <= 8'h00;
            sel_l <= TWS_SEL_RESET;
        end else begin
            {ak_m, ak_s, ak_d} <= {ack_tgl, ak_m, ak_s};
            if (ak_ev) begin
                rsp_l <= rsp_data;
                sel_l <= rsp_cfg;
            end
        end
    end

    // Memory side decode
    wire rq_ev = rq_s ^ rq_d;
    wire in_low = (req_addr <= TWS_WR_LIMIT);
    wire in_shadow = (req_addr >= TWS_SHADOW_LO) && (req_addr <= TWS_SHADOW_HI);
    wire wr_ok = rq_ev & req_we & (in_low | in_shadow);
    wire cfg_wr = wr_ok & (req_addr == TWS_CFG_OFFSET);
    wire [3:0] cfg_nx = cfg_wr ? req_wdata[7:TWS_SEL_LSB] : addr_select;
    // Unbacked addresses read FFh, never unknown
    wire [7:0] rd_data = (in_low | in_shadow) ? mem[req_addr] : TWS_READ_PAST;

    // Memory array writes
    always_ff @(posedge sys_clk) begin
        if (wr_ok) begin
            mem[req_addr] <= req_wdata;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            {rq_m, rq_s, rq_d} <= 3'h0;
            ack_tgl <= 1'b0;
            rsp_data <= 8'h00;
            rsp_cfg <= TWS_SEL_RESET;
            addr_select <= TWS_SEL_RESET;
        end else begin
            {rq_m, rq_s, rq_d} <= {req_tgl, rq_m, rq_s};
            addr_select <= cfg_nx;
            if (rq_ev) begin
                ack_tgl <= ~ack_tgl;
                rsp_cfg <= cfg_nx;
                rsp_data <= (req_addr == TWS_CFG_OFFSET) ? {addr_select, TWS_CFG_RSVD}
                                                          : rd_data;
            end
        end
    end

    // Checks on the link side and on the memory side
    property p_od_low;
        @(posedge link_clk) disable iff (!rst_n) sda_oe |-> !sda_out;
    endproperty
    a_od_low: assert property (p_od_low) else $error("data pin driven high");

    property p_start;
        @(posedge link_clk) disable iff (!rst_n) start_c |=> state == ST_ADDR && !sda_oe;
    endproperty
    a_start: assert property (p_start) else $error("start not taken");

    property p_stop;
        @(posedge link_clk) disable iff (!rst_n) stop_c |=> state == ST_IDLE && !sda_oe;
    endproperty
    a_stop: assert property (p_stop) else $error("stop not taken");

    property p_hit;
        @(posedge link_clk) disable iff (!rst_n)
            (state == ST_ADDR && fall_c && byte_done && addr_hit && !start_c && !stop_c)
            |=> state == ST_ACKT && sda_oe;
    endproperty
    a_hit: assert property (p_hit) else $error("own address not acknowledged");

    property p_miss;
        @(posedge link_clk) disable iff (!rst_n)
            (state == ST_ADDR && fall_c && byte_done && !addr_hit && !start_c && !stop_c)
            |=> state == ST_IGN ##1 !sda_oe;
    endproperty
    a_miss: assert property (p_miss) else $error("foreign address answered");

    property p_stable_high;
        @(posedge link_clk) disable iff (!rst_n)
            ($changed(sda_oe) && !$past(start_c) && !$past(stop_c)) |-> !$past(scl_s);
    endproperty
    a_stable_high: assert property (p_stable_high) else $error("data moved clock high");

    property p_ack_hold;
        @(posedge link_clk) disable iff (!rst_n)
            (state == ST_ACKT && !$past(start_c) && !$past(stop_c)) |-> sda_oe;
    endproperty
    a_ack_hold: assert property (p_ack_hold) else $error("acknowledge released early");

    property p_past_top;
        @(posedge link_clk) disable iff (!rst_n)
            (state == ST_ACKR && fall_c && !nak && ptr[8] && !start_c && !stop_c)
            |=> sh == 8'hff;
    endproperty
    a_past_top: assert property (p_past_top) else $error("past top not FFh");

    property p_nak_quiet;
        @(posedge link_clk) disable iff (!rst_n)
            (state == ST_ACKR && fall_c && nak && !start_c && !stop_c)
            |=> state == ST_IGN && !sda_oe;
    endproperty
    a_nak_quiet: assert property (p_nak_quiet) else $error("driving after refusal");

    property p_cfg_keep;
        @(posedge sys_clk) disable iff (!rst_n)
            !(rq_ev && req_we && req_addr == TWS_CFG_OFFSET) |=> $stable(addr_select);
    endproperty
    a_cfg_keep: assert property (p_cfg_keep) else $error("address select changed");
endmodule : tws_slave
